// >>> src/tspm_monitor.sv
// Thermal and supply protection monitor with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module tspm_monitor
    import tspm_pkg::*;
#(
    parameter int THERM_CYC = THERMAL_FILTER_CYC,
    parameter int OV5_CYC   = SUPPLY5_OV_FILTER_CYC
)(
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_n_i,
    // Comparators: above threshold, below threshold minus hysteresis
    input  wire logic [NUM_SENSORS-1:0] sensor_hot_i,
    input  wire logic [NUM_SENSORS-1:0] sensor_cool_i,
    input  wire logic                   trk_ilim_i,
    input  wire logic                   reg3v3_ilim_i,
    input  wire logic                   supply5_ov_i,
    input  wire logic                   supply3v3_uv_i,
    input  wire logic                   trk1_ov_i,
    input  wire logic                   trk2_ov_i,
    // Protection outputs
    output logic                        trk_supplies_off_o,
    output logic                        mrd_off_o,
    output logic                        reg3v3_off_o,
    output logic [NUM_OUTPUTS-1:0]      power_outputs_on_o,
    output logic [NUM_AUX-1:0]          aux_drivers_on_o,
    output logic                        irq_o,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready
);
    // Filter channels: 0..3 hot, 4..7 cool, 8 overvoltage
    localparam int NCH = 2 * NUM_SENSORS + 1;
    localparam int OVC = 2 * NUM_SENSORS;

    logic [NCH-1:0]            filt_in;          // Raw channel inputs
    logic [NCH-1:0]            filt_prev;        // Last sample per channel
    logic [NCH-1:0]            filt_out;         // Filtered level per channel
    logic [FILT_CNT_W-1:0]     filt_cnt [NCH];   // Stability counters
    logic [NUM_SENSORS-1:0]    therm;            // Filtered thermal shutdown state
    logic [NUM_SENSORS-1:0]    next_therm;
    logic                      ov_latch;         // Overvoltage shutdown until start command
    logic                      ov_prev;          // Edge detect of filtered overvoltage
    logic [STAT_W-1:0]         status;           // Sticky flags
    logic [STAT_W-1:0]         irq_mask;         // Interrupt enables
    logic [NUM_OUTPUTS-1:0]    out_en;           // Software output enables
    logic [NUM_AUX-1:0]        aux_en;           // Software igniter and CPS enables
    logic [LIVE_W-1:0]         live;             // Non-sticky diagnostics

    // Limit reached for a channel
    function automatic logic lim_hit(input logic [FILT_CNT_W-1:0] c, input int ch);
        lim_hit = (ch == OVC) ? (c == FILT_CNT_W'(OV5_CYC - 1)) : (c == FILT_CNT_W'(THERM_CYC - 1));
    endfunction

    assign filt_in = {supply5_ov_i, sensor_cool_i, sensor_hot_i};

    // Per-channel persistence filter; any change restarts the count
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            filt_prev <= '0;
            filt_out  <= '0;
            for (int i = 0; i < NCH; i++)
                filt_cnt[i] <= '0;
        end
        else
        begin
            filt_prev <= filt_in;
            for (int i = 0; i < NCH; i++)
            begin
                if (filt_in[i] != filt_prev[i])
                    filt_cnt[i] <= '0;
                else if (!lim_hit(filt_cnt[i], i))
                    filt_cnt[i] <= filt_cnt[i] + 1'b1;
                else
                    filt_out[i] <= filt_prev[i];
            end
        end
    end

    // Thermal state: filtered hot sets, filtered cool releases
    wire [NUM_SENSORS-1:0] hot_f  = filt_out[NUM_SENSORS-1:0];
    wire [NUM_SENSORS-1:0] cool_f = filt_out[OVC-1:NUM_SENSORS];
    wire                   ov_f   = filt_out[OVC];
    always_comb
    begin
        for (int i = 0; i < NUM_SENSORS; i++)
            next_therm[i] = hot_f[i] ? 1'b1 : (cool_f[i] ? 1'b0 : therm[i]);
    end

    // AXI write channel capture; address and data taken in either order
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire        wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire        wr_status = wr_fire && (aw_addr == ADDR_STATUS);
    wire        wr_mask   = wr_fire && (aw_addr == ADDR_IRQ_MASK) && w_strb[0];
    wire        wr_cmd    = wr_fire && (aw_addr == ADDR_CMD) && w_strb[0];
    wire        wr_outen  = wr_fire && (aw_addr == ADDR_OUT_EN);
    wire        wr_auxen  = wr_fire && (aw_addr == ADDR_AUX_EN) && w_strb[0];
    wire        wr_known  = (aw_addr == ADDR_STATUS) || (aw_addr == ADDR_IRQ_MASK) || (aw_addr == ADDR_LIVE)
                            || (aw_addr == ADDR_CMD) || (aw_addr == ADDR_OUT_EN) || (aw_addr == ADDR_AUX_EN);
    wire        start_cmd = wr_cmd && w_data[CMD_START_BIT];
    wire        rd_fire   = s_axi_arvalid && s_axi_arready;
    wire        rd_status = rd_fire && (s_axi_araddr == ADDR_STATUS);

    // Events that set sticky flags: filtered hot level and overvoltage edge
    wire [STAT_W-1:0] flag_set = {ov_f && !ov_prev, hot_f};
    // Flags clear on a status read; a coincident event still sets
    wire [STAT_W-1:0] next_status = flag_set | (rd_status ? '0 : status);

    // Byte-lane merge of the output enable register
    logic [31:0] outen_merged;
    always_comb
    begin
        outen_merged = {7'h00, out_en};
        for (int b = 0; b < 4; b++)
            if (w_strb[b])
                outen_merged[8*b +: 8] = w_data[8*b +: 8];
    end

    // Overvoltage clears non-exempt enables so software must rewrite them
    wire [NUM_OUTPUTS-1:0] next_out_en = (ov_f && !ov_prev) ? (out_en & OV_EXEMPT_MASK)
                                       : (wr_outen ? outen_merged[NUM_OUTPUTS-1:0] : out_en);

    // Protection decisions from filtered thermal state and the overvoltage latch
    wire next_trk_off = therm[SNS_TRK] && trk_ilim_i;
    wire next_reg_off = therm[SNS_REG] && reg3v3_ilim_i;
    wire next_mrd_off = therm[SNS_MRD];
    wire [NUM_OUTPUTS-1:0] ov_block = ov_latch ? ~OV_EXEMPT_MASK : '0;
    wire [NUM_OUTPUTS-1:0] next_pwr_on = therm[SNS_PWR] ? '0 : (out_en & ~ov_block);
    wire [NUM_AUX-1:0] next_aux_on = (therm[SNS_PWR] || ov_latch) ? '0 : aux_en;

    // Live diagnostics, recomputed every cycle
    wire [LIVE_W-1:0] next_live = {ov_latch,
                                   therm[SNS_TRK] || trk_ilim_i,
                                   trk2_ov_i,
                                   trk1_ov_i,
                                   supply3v3_uv_i,
                                   therm};

    // Protection and flag state
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            therm              <= '0;
            ov_prev            <= 1'b0;
            ov_latch           <= 1'b0;
            status             <= STATUS_RST;
            trk_supplies_off_o <= 1'b0;
            mrd_off_o          <= 1'b0;
            reg3v3_off_o       <= 1'b0;
            power_outputs_on_o <= '0;
            aux_drivers_on_o   <= '0;
            live               <= '0;
            irq_o              <= 1'b0;
        end
        else
        begin
            therm              <= next_therm;
            ov_prev            <= ov_f;
            // Shutdown set wins over a start command in the same cycle
            ov_latch           <= (ov_f && !ov_prev) ? 1'b1 : (start_cmd ? 1'b0 : ov_latch);
            status             <= next_status;
            trk_supplies_off_o <= next_trk_off;
            mrd_off_o          <= next_mrd_off;
            reg3v3_off_o       <= next_reg_off;
            power_outputs_on_o <= next_pwr_on;
            aux_drivers_on_o   <= next_aux_on;
            live               <= next_live;
            irq_o              <= |(next_status & irq_mask);
        end
    end

    // Software control registers
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            irq_mask <= MASK_RST;
            out_en   <= OUT_EN_RST;
            aux_en   <= AUX_EN_RST;
        end
        else
        begin
            out_en <= next_out_en;
            if (wr_mask)
                irq_mask <= w_data[STAT_W-1:0];
            if (ov_f && !ov_prev)
                aux_en <= '0;
            else if (wr_auxen)
                aux_en <= w_data[NUM_AUX-1:0];
        end
    end

    // AXI write handshake
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux; status reads return the value before clearing
    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (s_axi_araddr)
            ADDR_STATUS:   rd_mux = {27'h000_0000, status};
            ADDR_IRQ_MASK: rd_mux = {27'h000_0000, irq_mask};
            ADDR_LIVE:     rd_mux = {23'h00_0000, live};
            ADDR_CMD:      rd_mux = {31'h0000_0000, ov_latch};
            ADDR_OUT_EN:   rd_mux = {7'h00, out_en};
            ADDR_AUX_EN:   rd_mux = {24'h00_0000, aux_en};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end
    wire rd_known = (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_IRQ_MASK) || (s_axi_araddr == ADDR_LIVE)
                    || (s_axi_araddr == ADDR_CMD) || (s_axi_araddr == ADDR_OUT_EN) || (s_axi_araddr == ADDR_AUX_EN);

    // AXI read handshake: one outstanding read
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    sequence s_ov_rise;
        ov_f && !ov_prev;
    endsequence
    sequence s_ov_shut;
        ov_latch ##1 ((power_outputs_on_o & ~OV_EXEMPT_MASK) == '0);
    endsequence

    AST_PWR_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        therm[SNS_PWR] |=> (power_outputs_on_o == '0) && (aux_drivers_on_o == '0))
        else $error("power stage not off while hot");
    AST_MRD_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(therm[SNS_MRD]) |=> mrd_off_o)
        else $error("relay driver not off while hot");
    AST_REG_AND: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (therm[SNS_REG] && !reg3v3_ilim_i) |=> !reg3v3_off_o)
        else $error("3v3 off without current limit");
    AST_TRK_AND: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (therm[SNS_TRK] && trk_ilim_i) |=> trk_supplies_off_o)
        else $error("tracking supplies not off");
    AST_RECOVER: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (cool_f[SNS_PWR] && !hot_f[SNS_PWR] && !ov_latch) |=> ##1 (power_outputs_on_o == $past(out_en)))
        else $error("outputs not restored after cooling");
    AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hot_f[SNS_MRD] |=> status[SNS_MRD])
        else $error("warning flag not set");
    AST_RD_CLR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (rd_status && !hot_f[SNS_TRK]) |=> !status[SNS_TRK])
        else $error("warning flag not cleared by read");
    AST_OV_SHUT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_ov_rise |=> s_ov_shut)
        else $error("overvoltage shutdown missing");
    AST_OV_FLAG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_ov_rise |=> status[ST_OV5_BIT] [*1] ##0 ov_latch)
        else $error("overvoltage flag not set");
    AST_FILT_RST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (filt_in[SNS_PWR] != filt_prev[SNS_PWR]) |=> (filt_cnt[SNS_PWR] == '0))
        else $error("filter count not restarted");
    AST_LIVE_DIAG: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        trk_ilim_i |=> live[LV_TRKD_BIT])
        else $error("combined tracking diag missing");
endmodule
`default_nettype wire

// >>> include/tspm_pkg.sv
// Constants, register map and timing for the thermal and supply protection monitor
// How it works
// - Hot tracking sensor with current limit: supplies off
// - Hot power stage: all outputs and igniters off
// - Hot relay sensor: main relay driver off
// - Hot 3.3 V sensor with current limit: regulator off
// - Filtered cool indication restores outputs automatically
// - Sticky warning flag per temperature sensor
// - Reading the warning flags clears them
// - Flags and overvoltage shutdown latch; thermal shutdown follows filtered state
// - Filtered 5 V overvoltage: drivers off, some exempt
// - Sticky 5 V overvoltage flag, cleared by read
// - Overvoltage flag alone never blocks switch on
// - 3.3 V shutdown is thermal AND over-current
// - Live 3.3 V undervoltage status bit
// - Live per-channel tracking overvoltage bits
// - Tracking shutdown is thermal AND over-current
// - Live combined tracking overload or overtemperature bit
package tspm_pkg;
    // Clock and timing
    localparam int CLK_FREQ_MHZ           = 250;
    localparam int THERMAL_FILTER_TIME_NS = 20000;
    localparam int SUPPLY5_OV_FILTER_TIME_NS = 10000;
    localparam int THERMAL_FILTER_CYC     = (THERMAL_FILTER_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int SUPPLY5_OV_FILTER_CYC  = (SUPPLY5_OV_FILTER_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int FILT_CNT_W             = 16;

    // Register byte offsets
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
    localparam logic [7:0] ADDR_LIVE     = 8'h08;
    localparam logic [7:0] ADDR_CMD      = 8'h0C;
    localparam logic [7:0] ADDR_OUT_EN   = 8'h10;
    localparam logic [7:0] ADDR_AUX_EN   = 8'h14;

    // Field layout
    localparam int NUM_SENSORS  = 4;
    localparam int NUM_OUTPUTS  = 25;
    localparam int NUM_AUX      = 8;
    localparam int STAT_W       = 5;
    localparam int ST_OV5_BIT   = 4;
    localparam int LIVE_W       = 9;
    localparam int LV_UV33_BIT  = 4;
    localparam int LV_TRK1_BIT  = 5;
    localparam int LV_TRK2_BIT  = 6;
    localparam int LV_TRKD_BIT  = 7;
    localparam int LV_OVL_BIT   = 8;
    localparam int CMD_START_BIT = 0;
    localparam int SNS_TRK      = 0;
    localparam int SNS_PWR      = 1;
    localparam int SNS_MRD      = 2;
    localparam int SNS_REG      = 3;

    // Outputs 13, 14, 21 and 25 survive an overvoltage shutdown
    localparam logic [NUM_OUTPUTS-1:0] OV_EXEMPT_MASK = 25'h110_3000;

    // Reset values
    localparam logic [STAT_W-1:0]      STATUS_RST = 5'h00;
    localparam logic [STAT_W-1:0]      MASK_RST   = 5'h00;
    localparam logic [NUM_OUTPUTS-1:0] OUT_EN_RST = 25'h000_0000;
    localparam logic [NUM_AUX-1:0]     AUX_EN_RST = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> verification/tspm_mcu_model.sv
// Microcontroller model: AXI4-Lite master that reads flags and writes controls
`timescale 1ns/100ps
`default_nettype none
module tspm_mcu_model (
    input  wire logic        clk_i,
    output logic [7:0]       awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic [3:0]       wstrb_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic [1:0]  bresp_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [7:0]       araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic [1:0]  rresp_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    // Idle bus at time zero
    initial
    begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {awaddr_o, wdata_o, wstrb_o} <= {a, d, 4'hF};
        {awvalid_o, wvalid_o, bready_o} <= 3'b111;
        forever
        begin
            @(posedge clk_i);
            // Released address and data lines show the inverse; the write strobes keep their value
            if (awvalid_o && awready_i)
                {awvalid_o, awaddr_o} <= {1'b0, ~a};
            if (wvalid_o && wready_i)
                {wvalid_o, wdata_o} <= {1'b0, ~d};
            if (bvalid_i)
                break;
        end
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    // Read: the flag read is also what acknowledges a warning
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        araddr_o <= a;
        {arvalid_o, rready_o} <= 2'b11;
        forever
        begin
            @(posedge clk_i);
            if (arvalid_o && arready_i)
                {arvalid_o, araddr_o} <= {1'b0, ~a};
            if (rvalid_i)
                break;
        end
        {d, r} = {rdata_i, rresp_i};
        rready_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verification/tspm_monitor_test.sv
// Self-checking bench for the thermal and supply protection monitor
`timescale 1ns/100ps
`default_nettype none
module tspm_monitor_test;
    import tspm_pkg::*;
    localparam int TC = 8;                              // Short filter keeps the run brief
    localparam logic [24:0] ALL_OUT = 25'h1FF_FFFF;     // Every power output requested
    logic clk_sys_i, rst_n_i, trk_ilim_i, reg3v3_ilim_i, supply5_ov_i, supply3v3_uv_i, trk1_ov_i, trk2_ov_i;
    logic [3:0]  sensor_hot_i, sensor_cool_i, s_axi_wstrb;
    logic        trk_supplies_off_o, mrd_off_o, reg3v3_off_o, irq_o;
    logic [24:0] power_outputs_on_o;
    logic [7:0]  aux_drivers_on_o, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          err_count, checks_done, cyc;
    tspm_monitor #(.THERM_CYC(TC), .OV5_CYC(TC)) dut_u (
        .clk_sys_i, .rst_n_i, .sensor_hot_i, .sensor_cool_i, .trk_ilim_i, .reg3v3_ilim_i, .supply5_ov_i,
        .supply3v3_uv_i, .trk1_ov_i, .trk2_ov_i, .trk_supplies_off_o, .mrd_off_o, .reg3v3_off_o,
        .power_outputs_on_o, .aux_drivers_on_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tspm_mcu_model mcu_u (
        .clk_i(clk_sys_i), .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid), .awready_i(s_axi_awready),
        .wdata_o(s_axi_wdata), .wstrb_o(s_axi_wstrb), .wvalid_o(s_axi_wvalid), .wready_i(s_axi_wready),
        .bresp_i(s_axi_bresp), .bvalid_i(s_axi_bvalid), .bready_o(s_axi_bready), .araddr_o(s_axi_araddr),
        .arvalid_o(s_axi_arvalid), .arready_i(s_axi_arready), .rdata_i(s_axi_rdata), .rresp_i(s_axi_rresp),
        .rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready));
    // Comparison with count and report
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Register access; addresses beyond the map answer with an error
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mcu_u.wr(a, d, rsp);
        check("bresp", 32'(rsp), 32'((a > ADDR_AUX_EN) ? RESP_SLVERR : RESP_OKAY));
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        mcu_u.rd(a, rd, rsp);
        check(what, rd, exp);
        check("rresp", 32'(rsp), 32'((a > ADDR_AUX_EN) ? RESP_SLVERR : RESP_OKAY));
    endtask
    // Reset values and an unmapped place
    task automatic t_reset();
        rd_chk("status rst", ADDR_STATUS, 32'(STATUS_RST));
        rd_chk("mask rst", ADDR_IRQ_MASK, 32'(MASK_RST));
        rd_chk("out_en rst", ADDR_OUT_EN, 32'(OUT_EN_RST));
        rd_chk("unmapped", 8'h40, 32'h0);
        wr(8'h40, 32'h1);
        check("outs rst", 32'(power_outputs_on_o), 32'h0);
    endtask
    // Each sensor hot with current limit, then cool; flags read late
    task automatic t_sensors();
        logic [3:0] offs;
        for (int i = 0; i < NUM_SENSORS; i++)
        begin
            wr(ADDR_OUT_EN, 32'(ALL_OUT));
            wr(ADDR_AUX_EN, 32'h0000_00FF);
            @(posedge clk_sys_i) sensor_hot_i <= 4'(1 << i);
            wait_cyc(3 * TC);
            offs = {reg3v3_off_o, mrd_off_o, ~|{aux_drivers_on_o, power_outputs_on_o}, trk_supplies_off_o};
            check("shutdown", 32'(offs), 32'(1 << i));
            check("irq set", 32'(irq_o), 32'h1);
            rd_chk("flag", ADDR_STATUS, 32'(1 << i));
            @(posedge clk_sys_i)
            begin
                sensor_hot_i <= 4'h0;
                sensor_cool_i <= 4'(1 << i);
            end
            wait_cyc(3 * TC);
            check("restored", 32'({reg3v3_off_o, mrd_off_o, trk_supplies_off_o}), 32'h0);
            check("outs back", 32'(power_outputs_on_o), 32'(ALL_OUT));
            check("aux back", 32'(aux_drivers_on_o), 32'h0000_00FF);
            rd_chk("flag kept", ADDR_STATUS, 32'(1 << i));
            rd_chk("flag clr", ADDR_STATUS, 32'h0);
            wait_cyc(2);
            check("irq clr", 32'(irq_o), 32'h0);
            @(posedge clk_sys_i) sensor_cool_i <= 4'h0;
        end
    endtask
    // Hot without current limit keeps the supplies on; irq masked
    task automatic t_no_ilim();
        wr(ADDR_IRQ_MASK, 32'h0);
        @(posedge clk_sys_i) {trk_ilim_i, reg3v3_ilim_i, sensor_hot_i} <= {2'b00, 4'h9};
        wait_cyc(3 * TC);
        check("no ilim", 32'({reg3v3_off_o, trk_supplies_off_o}), 32'h0);
        check("irq masked", 32'(irq_o), 32'h0);
        rd_chk("live hot", ADDR_LIVE, 32'h0000_0089);
        @(posedge clk_sys_i) trk_ilim_i <= 1'b1;
        wait_cyc(4);
        check("trk ilim", 32'({reg3v3_off_o, trk_supplies_off_o}), 32'h1);
        @(posedge clk_sys_i) {trk_ilim_i, sensor_hot_i, sensor_cool_i} <= {1'b0, 4'h0, 4'h9};
        wait_cyc(3 * TC);
        @(posedge clk_sys_i) sensor_cool_i <= 4'h0;
        rd_chk("live cool", ADDR_LIVE, 32'h0);
        rd_chk("flags", ADDR_STATUS, 32'h0000_0009);
    endtask
    // Hot pulses shorter than the filter never take effect
    task automatic t_glitch();
        repeat (6)
        begin
            @(posedge clk_sys_i) sensor_hot_i <= 4'h4;
            wait_cyc(TC - 2);
            @(posedge clk_sys_i) sensor_hot_i <= 4'h0;
            wait_cyc(TC - 2);
        end
        check("glitch", 32'(mrd_off_o), 32'h0);
        rd_chk("glitch flag", ADDR_STATUS, 32'h0);
    endtask
    // Live diagnostics follow their inputs
    task automatic t_live();
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_sys_i) {trk2_ov_i, trk1_ov_i, supply3v3_uv_i} <= 3'((1 << k) & 7);
            wait_cyc(3);
            rd_chk("live diag", ADDR_LIVE, 32'(((1 << k) & 7) << LV_UV33_BIT));
        end
    endtask
    // 5 V overvoltage, then restart and rewrite of the controls
    task automatic t_ov();
        wr(ADDR_OUT_EN, 32'(ALL_OUT));
        wr(ADDR_AUX_EN, 32'h0000_00FF);
        @(posedge clk_sys_i) supply5_ov_i <= 1'b1;
        wait_cyc(3 * TC);
        check("ov outs", 32'(power_outputs_on_o), 32'(OV_EXEMPT_MASK));
        check("ov aux mrd", 32'({mrd_off_o, aux_drivers_on_o}), 32'h0);
        @(posedge clk_sys_i) supply5_ov_i <= 1'b0;
        wait_cyc(3 * TC);
        wr(ADDR_OUT_EN, 32'(ALL_OUT));
        wait_cyc(3);
        check("no restart", 32'(power_outputs_on_o), 32'(OV_EXEMPT_MASK));
        rd_chk("ov latch", ADDR_CMD, 32'h1);
        rd_chk("live ov", ADDR_LIVE, 32'(1 << LV_OVL_BIT));
        wr(ADDR_CMD, 32'(1 << CMD_START_BIT));
        wr(ADDR_OUT_EN, 32'(ALL_OUT));
        wr(ADDR_AUX_EN, 32'h0000_00FF);
        wait_cyc(3);
        check("restart", 32'(power_outputs_on_o), 32'(ALL_OUT));
        check("aux restart", 32'(aux_drivers_on_o), 32'h0000_00FF);
        rd_chk("ov flag", ADDR_STATUS, 32'(1 << ST_OV5_BIT));
        rd_chk("ov clr", ADDR_STATUS, 32'h0);
    endtask
    task automatic test_done();
        $display("Checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Clock at 250 MHz
    initial
    begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // Hang guard far above the expected run of under a thousand cycles
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            test_done();
        end
    end
    // Main sequence
    initial
    begin
        {rst_n_i, trk_ilim_i, reg3v3_ilim_i, supply5_ov_i, supply3v3_uv_i, trk1_ov_i, trk2_ov_i} = '0;
        {sensor_hot_i, sensor_cool_i, err_count, checks_done, cyc} = '0;
        wait_cyc(4);
        @(posedge clk_sys_i) {rst_n_i, trk_ilim_i, reg3v3_ilim_i} <= 3'b111;
        wait_cyc(2);
        t_reset();
        wr(ADDR_IRQ_MASK, 32'h0000_001F);
        t_sensors();
        t_no_ilim();
        t_glitch();
        t_live();
        t_ov();
        test_done();
    end
endmodule
`default_nettype wire
